// File: src/brd_core.sv
`timescale 1ns/1ps
module brd_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [brd_pkg::APB_AW-1:0] paddr,
  input wire logic [brd_pkg::APB_DW-1:0] pwdata,
  output logic [brd_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction fetch
  output logic [brd_pkg::PC_W-1:0] fetch_addr,
  output logic fetch_en,
  input wire logic [brd_pkg::INSTR_W-1:0] fetch_data,
  // Data memory
  output brd_pkg::brd_dmem_req_s dmem_req,
  input wire logic [brd_pkg::DATA_W-1:0] dmem_rdata,
  // Execution status
  output logic pc_write,
  output logic branch_taken
);
  import brd_pkg::*;

  brd_phase_e phase;
  logic cycle_end;

  // Software control state
  logic run_reg;
  logic run_next;
  logic [BANK_W-1:0] bank_reg;
  logic [BANK_W-1:0] bank_next;
  brd_flags_s flags_reg;
  brd_flags_s flags_next;

  // Execution state
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [INSTR_W-1:0] instr_reg;
  logic [INSTR_W-1:0] instr_next;
  brd_kind_e kind_reg;
  brd_kind_e kind_next;
  logic [PC_W-1:0] ofs_reg;
  logic [PC_W-1:0] ofs_next;
  logic [PC_W-1:0] target_reg;
  logic [PC_W-1:0] target_next;
  logic taken_reg;
  logic taken_next;
  logic flush_reg;
  logic flush_next;
  logic [DATA_W-1:0] fdata_reg;
  logic [DATA_W-1:0] fdata_next;
  brd_dmem_req_s dmem_reg;
  brd_dmem_req_s dmem_next;
  logic pc_write_reg;
  logic pc_write_next;
  logic last_taken_reg;
  logic last_taken_next;
  brd_kind_e last_kind_reg;
  brd_kind_e last_kind_next;
  logic [RETIRED_W-1:0] retired_reg;
  logic [RETIRED_W-1:0] retired_next;

  // Decode helpers
  brd_kind_e kind_dec;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0] bit_mask;
  logic cond_true;
  logic fetch_now;

  // APB decode
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;

  brd_qphase u_qphase (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_reg),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // Fetch is skipped in the cycle that follows a redirect
  assign fetch_now = (phase == PH_Q1) && run_reg && !flush_reg;

  // Opcode decode of the word on the fetch bus
  always_comb begin
    kind_dec = K_NOP;
    if (fetch_data[INSTR_W-1 -: 8] == OPC_CARRY_CLEAR) begin
      kind_dec = K_CARRY_CLEAR;
    end else if (fetch_data[INSTR_W-1 -: 8] == OPC_NEGATIVE_CLEAR) begin
      kind_dec = K_NEGATIVE_CLEAR;
    end else if (fetch_data[INSTR_W-1 -: 8] == OPC_OVERFLOW_CLEAR) begin
      kind_dec = K_OVERFLOW_CLEAR;
    end else if (fetch_data[INSTR_W-1 -: 8] == OPC_ZERO_CLEAR) begin
      kind_dec = K_ZERO_CLEAR;
    end else if (fetch_data[INSTR_W-1 -: 5] == OPC_REL_BRANCH) begin
      kind_dec = K_REL_BRANCH;
    end else if (fetch_data[INSTR_W-1 -: 4] == OPC_FILE_BIT_SET) begin
      kind_dec = K_FILE_BIT_SET;
    end
  end

  // Operand address from the word on the fetch bus, ready to latch at the end of Q1
  always_comb begin
    file_addr = file_addr_from(fetch_data);
  end

  assign bit_mask = DATA_W'(1) << instr_reg[FLD_BIT_LSB +: BIT_SEL_W];

  // Conditional branches test a clear flag; the relative branch is always taken
  always_comb begin
    unique case (kind_reg)
      K_CARRY_CLEAR: cond_true = !flags_reg.c;
      K_NEGATIVE_CLEAR: cond_true = !flags_reg.n;
      K_OVERFLOW_CLEAR: cond_true = !flags_reg.ov;
      K_ZERO_CLEAR: cond_true = !flags_reg.z;
      K_REL_BRANCH: cond_true = 1'b1;
      K_NOP, K_FILE_BIT_SET: cond_true = 1'b0;
      default: cond_true = 1'b0;
    endcase
  end

  // Phase sequenced execution
  always_comb begin
    pc_next = pc_reg;
    instr_next = instr_reg;
    kind_next = kind_reg;
    ofs_next = ofs_reg;
    target_next = target_reg;
    taken_next = taken_reg;
    flush_next = flush_reg;
    fdata_next = fdata_reg;
    dmem_next = dmem_reg;
    pc_write_next = 1'b0;
    last_taken_next = last_taken_reg;
    last_kind_next = last_kind_reg;
    retired_next = retired_reg;
    unique case (phase)
      PH_Q1: begin
        taken_next = 1'b0;
        if (fetch_now) begin
          instr_next = fetch_data;
          kind_next = kind_dec;
          pc_next = pc_reg + PC_STEP;
          if (kind_dec == K_FILE_BIT_SET) begin
            dmem_next.rd = 1'b1;
            dmem_next.addr = file_addr;
          end
        end else begin
          kind_next = K_NOP;
        end
      end
      PH_Q2: begin
        // Offset held pre-doubled so Q3 is one adder
        if (kind_reg == K_REL_BRANCH) begin
          ofs_next = PC_W'({{(PC_W-LONG_OFS_W-1){instr_reg[LONG_OFS_W-1]}},
                            instr_reg[LONG_OFS_W-1:0], 1'b0});
        end else begin
          ofs_next = PC_W'({{(PC_W-SHORT_OFS_W-1){instr_reg[SHORT_OFS_W-1]}},
                            instr_reg[SHORT_OFS_W-1:0], 1'b0});
        end
        if (kind_reg == K_FILE_BIT_SET) begin
          fdata_next = dmem_rdata;
          dmem_next.rd = 1'b0;
        end
      end
      PH_Q3: begin
        // Counter already points past this word
        target_next = pc_reg + ofs_reg;
        taken_next = cond_true;
        if (kind_reg == K_FILE_BIT_SET) begin
          dmem_next.wdata = fdata_reg | bit_mask;
          dmem_next.wr = 1'b1;
        end
      end
      PH_Q4: begin
        // Taken flag stands for Q4 only
        taken_next = 1'b0;
        if (taken_reg) begin
          pc_next = target_reg;
          pc_write_next = 1'b1;
        end
        // A taken branch costs one extra, idle cycle
        flush_next = taken_reg;
        dmem_next.wr = 1'b0;
        if (cycle_end && !flush_reg) begin
          last_taken_next = taken_reg;
          last_kind_next = kind_reg;
          retired_next = retired_reg + RETIRED_W'(1);
        end
      end
      default: begin
        taken_next = 1'b0;
      end
    endcase
    // Software may load the counter only while stopped
    if (apb_wr && paddr == OFS_PC && !run_reg && phase == PH_Q1) begin
      pc_next = {pwdata[PC_W-1:1], 1'b0};
      flush_next = 1'b0;
    end
  end

  // Same banking applied to a word not yet latched
  function automatic logic [FADDR_W-1:0] file_addr_from(input logic [INSTR_W-1:0] w);
    logic [FADDR_W-1:0] a;
    a = {bank_reg, w[FLD_FILE_LSB +: 8]};
    if (!w[FLD_ACCESS]) begin
      if (w[FLD_FILE_LSB +: 8] < ACCESS_SPLIT) begin
        a = {ACCESS_LO_BANK, w[FLD_FILE_LSB +: 8]};
      end else begin
        a = {ACCESS_HI_BANK, w[FLD_FILE_LSB +: 8]};
      end
    end
    return a;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= PC_RST;
      instr_reg <= INSTR_RST;
      kind_reg <= K_NOP;
      ofs_reg <= '0;
      target_reg <= '0;
      taken_reg <= 1'b0;
      flush_reg <= 1'b0;
      fdata_reg <= '0;
      dmem_reg <= '0;
      pc_write_reg <= 1'b0;
      last_taken_reg <= 1'b0;
      last_kind_reg <= K_NOP;
      retired_reg <= '0;
    end else begin
      pc_reg <= pc_next;
      instr_reg <= instr_next;
      kind_reg <= kind_next;
      ofs_reg <= ofs_next;
      target_reg <= target_next;
      taken_reg <= taken_next;
      flush_reg <= flush_next;
      fdata_reg <= fdata_next;
      dmem_reg <= dmem_next;
      pc_write_reg <= pc_write_next;
      last_taken_reg <= last_taken_next;
      last_kind_reg <= last_kind_next;
      retired_reg <= retired_next;
    end
  end

  // APB slave, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_BANK, OFS_FLAGS, OFS_PC, OFS_STATUS, OFS_RETIRED: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  // Flags are software state here; bit set never touches them
  always_comb begin
    run_next = run_reg;
    bank_next = bank_reg;
    flags_next = flags_reg;
    if (apb_wr) begin
      unique case (paddr)
        OFS_CTRL: run_next = pwdata[CTRL_RUN_BIT];
        OFS_BANK: bank_next = pwdata[BANK_W-1:0];
        OFS_FLAGS: begin
          flags_next.c = pwdata[FLAG_C_BIT];
          flags_next.z = pwdata[FLAG_Z_BIT];
          flags_next.ov = pwdata[FLAG_OV_BIT];
          flags_next.n = pwdata[FLAG_N_BIT];
        end
        default: begin
          run_next = run_reg;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= CTRL_RUN_RST;
      bank_reg <= BANK_RST;
      flags_reg <= FLAGS_RST;
    end else begin
      run_reg <= run_next;
      bank_reg <= bank_next;
      flags_reg <= flags_next;
    end
  end

  // Read mux over flopped state
  always_comb begin
    prdata = '0;
    if (apb_rd) begin
      unique case (paddr)
        OFS_CTRL: prdata[CTRL_RUN_BIT] = run_reg;
        OFS_BANK: prdata[BANK_W-1:0] = bank_reg;
        OFS_FLAGS: begin
          prdata[FLAG_C_BIT] = flags_reg.c;
          prdata[FLAG_Z_BIT] = flags_reg.z;
          prdata[FLAG_OV_BIT] = flags_reg.ov;
          prdata[FLAG_N_BIT] = flags_reg.n;
        end
        OFS_PC: prdata[PC_W-1:0] = pc_reg;
        OFS_STATUS: begin
          prdata[STAT_KIND_LSB +: 7] = last_kind_reg;
          prdata[STAT_TAKEN_BIT] = last_taken_reg;
          prdata[STAT_FLUSH_BIT] = flush_reg;
          prdata[STAT_PHASE_LSB +: 4] = phase;
        end
        OFS_RETIRED: prdata[RETIRED_W-1:0] = retired_reg;
        default: prdata = '0;
      endcase
    end
  end

  assign fetch_addr = pc_reg;
  assign fetch_en = fetch_now;
  assign dmem_req = dmem_reg;
  assign pc_write = pc_write_reg;
  assign branch_taken = taken_reg;

endmodule // brd_core

// File: src/brd_pkg.sv
package brd_pkg;

  // Widths
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int BANK_W = 4;
  localparam int FADDR_W = 12;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int SHORT_OFS_W = 8;
  localparam int LONG_OFS_W = 11;
  localparam int BIT_SEL_W = 3;
  localparam int RETIRED_W = 16;

  // Opcode patterns
  localparam logic [7:0] OPC_CARRY_CLEAR = 8'he3;
  localparam logic [7:0] OPC_NEGATIVE_CLEAR = 8'he7;
  localparam logic [7:0] OPC_OVERFLOW_CLEAR = 8'he5;
  localparam logic [7:0] OPC_ZERO_CLEAR = 8'he1;
  localparam logic [4:0] OPC_REL_BRANCH = 5'h1a;
  localparam logic [3:0] OPC_FILE_BIT_SET = 4'h8;

  // Instruction field positions
  localparam int FLD_OPC8_LSB = 8;
  localparam int FLD_OPC5_LSB = 11;
  localparam int FLD_OPC4_LSB = 12;
  localparam int FLD_BIT_LSB = 9;
  localparam int FLD_ACCESS = 8;
  localparam int FLD_FILE_LSB = 0;

  // Program counter step per word
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Access bank layout
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

  // Register offsets
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_BANK = 8'h04;
  localparam logic [APB_AW-1:0] OFS_FLAGS = 8'h08;
  localparam logic [APB_AW-1:0] OFS_PC = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] OFS_RETIRED = 8'h14;

  // Field positions inside registers
  localparam int CTRL_RUN_BIT = 0;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_Z_BIT = 1;
  localparam int FLAG_OV_BIT = 2;
  localparam int FLAG_N_BIT = 3;
  localparam int STAT_KIND_LSB = 0;
  localparam int STAT_TAKEN_BIT = 8;
  localparam int STAT_FLUSH_BIT = 9;
  localparam int STAT_PHASE_LSB = 12;

  // Reset values
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } brd_phase_e;

  typedef enum logic [6:0] {
    K_NOP = 7'b0000001,
    K_CARRY_CLEAR = 7'b0000010,
    K_NEGATIVE_CLEAR = 7'b0000100,
    K_OVERFLOW_CLEAR = 7'b0001000,
    K_ZERO_CLEAR = 7'b0010000,
    K_REL_BRANCH = 7'b0100000,
    K_FILE_BIT_SET = 7'b1000000
  } brd_kind_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic c;
  } brd_flags_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } brd_dmem_req_s;

endpackage

// File: src/brd_qphase.sv
`timescale 1ns/1ps
module brd_qphase (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  // Phase
  output brd_pkg::brd_phase_e phase,
  output logic cycle_end
);
  import brd_pkg::*;

  brd_phase_e phase_reg;
  brd_phase_e phase_next;

  // Stopping only at Q1 keeps every instruction cycle whole
  always_comb begin
    unique case (phase_reg)
      PH_Q1: phase_next = run ? PH_Q2 : PH_Q1;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
      default: phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
  assign cycle_end = (phase_reg == PH_Q4);

endmodule // brd_qphase

// File: verif/brd_core_chk.sv
`timescale 1ns/1ps
module brd_core_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [brd_pkg::APB_AW-1:0] paddr,
  input wire logic [brd_pkg::APB_DW-1:0] pwdata,
  input wire logic [brd_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fetch and data
  input wire logic [brd_pkg::PC_W-1:0] fetch_addr,
  input wire logic fetch_en,
  input wire logic [brd_pkg::INSTR_W-1:0] fetch_data,
  input wire brd_pkg::brd_dmem_req_s dmem_req,
  input wire logic [brd_pkg::DATA_W-1:0] dmem_rdata,
  // Status
  input wire logic pc_write,
  input wire logic branch_taken
);
  import brd_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_FETCH_GAP: assert property (fetch_en |=> !fetch_en [*3])
    else $error("fetch repeated inside one cycle");
  AST_PC_STEP: assert property (fetch_en |=> fetch_addr == $past(fetch_addr) + PC_STEP)
    else $error("counter not stepped after fetch");
  AST_TAKEN_WRITE: assert property (branch_taken |=> pc_write && !branch_taken)
    else $error("taken branch without counter write");
  AST_IDLE_CYCLE: assert property (pc_write |-> !fetch_en [*4])
    else $error("fetch during idle cycle");
  AST_TARGET_HOLD: assert property (pc_write |=> $stable(fetch_addr) [*3])
    else $error("counter moved during idle cycle");
  AST_RD_WR: assert property (dmem_req.wr |-> $past(dmem_req.rd, 2))
    else $error("write not two clocks after read");
  AST_ADDR_HOLD: assert property (dmem_req.rd |=> $stable(dmem_req.addr) [*2])
    else $error("data address moved");
  AST_FILE_LOW: assert property (dmem_req.rd |-> dmem_req.addr[7:0] == $past(fetch_data[7:0]))
    else $error("file address wrong");
  AST_ACCESS_BANK: assert property (dmem_req.rd && !$past(fetch_data[8])
    |-> dmem_req.addr[11:8] == {4{$past(fetch_data[7])}})
    else $error("access bank wrong");
  AST_SET_DATA: assert property (dmem_req.wr
    |-> dmem_req.wdata == ($past(dmem_rdata, 2) | (8'h01 << $past(fetch_data[11:9], 3))))
    else $error("bit set data wrong");
endmodule // brd_core_chk
bind brd_core brd_core_chk i_brd_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fetch_addr(fetch_addr), .fetch_en(fetch_en), .fetch_data(fetch_data), .dmem_req(dmem_req),
  .dmem_rdata(dmem_rdata), .pc_write(pc_write), .branch_taken(branch_taken));

// File: verif/branch_and_bit_set_decode_tb_top.sv
`timescale 1ns/1ps
module branch_and_bit_set_decode_tb_top;
  import brd_pkg::*;
  localparam logic [PC_W-1:0] START = 21'h000100;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [APB_DW-1:0] pwdata = 32'h0;
  logic [APB_DW-1:0] prdata;
  logic pready, pslverr, fetch_en, pc_write, branch_taken;
  logic [PC_W-1:0] fetch_addr;
  logic [INSTR_W-1:0] prog [1024];
  logic [DATA_W-1:0] dmem [4096];
  brd_dmem_req_s dmem_req;
  logic [FADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  int fail_count = 0;
  int checks_done = 0;

  always #50 pclk = ~pclk;

  // Memories answer combinationally, as the core expects
  brd_core i_brd_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .fetch_en(fetch_en), .fetch_data(prog[fetch_addr[10:1]]), .dmem_req(dmem_req),
    .dmem_rdata(dmem[dmem_req.addr]), .pc_write(pc_write), .branch_taken(branch_taken));

  task automatic chk(input string what, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stopping only lands at Q1, hence the wait before loading the counter
  task automatic exec(input logic [15:0] ins, input logic [3:0] fl, output int gap, output logic [20:0] nxt);
    logic [31:0] r;
    logic e;
    apb(1'b1, OFS_CTRL, 32'h0, r, e);
    repeat (8) @(posedge pclk);
    prog[START[10:1]] <= ins;
    apb(1'b1, OFS_FLAGS, {28'h0, fl}, r, e);
    apb(1'b1, OFS_PC, {11'h0, START}, r, e);
    apb(1'b1, OFS_CTRL, 32'h1, r, e);
    wa = '0;
    wd = '0;
    do begin
      @(posedge pclk);
    end while (!(fetch_en === 1'b1 && fetch_addr === START));
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
      if (dmem_req.wr === 1'b1) begin
        wa = dmem_req.addr;
        wd = dmem_req.wdata;
      end
    end while (fetch_en !== 1'b1);
    nxt = fetch_addr;
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, OFS_PC, 32'h0, r, e);
    chk("pc reset", r, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", e, 32'h1);
  endtask

  task automatic t_cond();
    logic [7:0] opc [4] = '{OPC_CARRY_CLEAR, OPC_ZERO_CLEAR, OPC_OVERFLOW_CLEAR, OPC_NEGATIVE_CLEAR};
    logic [7:0] ofs [4] = '{8'h80, 8'h7f, 8'h01, 8'hfe};
    int gap;
    logic [20:0] nxt;
    for (int k = 0; k < 4; k++) begin
      // Own flag clear, the rest set
      exec({opc[k], ofs[k]}, 4'hf ^ (4'h1 << k), gap, nxt);
      chk("taken gap", gap, 8);
      chk("taken target", nxt, PC_W'(START + 21'd2 + {{12{ofs[k][7]}}, ofs[k], 1'b0}));
      exec({opc[k], ofs[k]}, 4'h1 << k, gap, nxt);
      chk("fall gap", gap, 4);
      chk("fall addr", nxt, START + 21'd2);
    end
  endtask

  task automatic t_bra();
    logic [10:0] ofs [2] = '{11'h3ff, 11'h400};
    int gap;
    logic [20:0] nxt;
    for (int k = 0; k < 2; k++) begin
      exec({OPC_REL_BRANCH, ofs[k]}, 4'hf, gap, nxt);
      chk("rel gap", gap, 8);
      chk("rel target", nxt, PC_W'(START + 21'd2 + {{9{ofs[k][10]}}, ofs[k], 1'b0}));
    end
  endtask

  task automatic t_bitset();
    logic [11:0] ins [3] = '{12'hf34, 12'h020, 12'h690};
    logic [11:0] adr [3] = '{12'h534, 12'h020, 12'hf90};
    logic [7:0] old [3] = '{8'h0a, 8'h0a, 8'h55};
    logic [7:0] nw [3] = '{8'h8a, 8'h0b, 8'h5d};
    logic [31:0] r;
    logic e;
    int gap;
    logic [20:0] nxt;
    apb(1'b1, OFS_BANK, 32'h5, r, e);
    for (int k = 0; k < 3; k++) begin
      dmem[adr[k]] <= old[k];
      exec({OPC_FILE_BIT_SET, ins[k]}, 4'ha, gap, nxt);
      chk("set gap", gap, 4);
      chk("set addr", wa, adr[k]);
      chk("set data", wd, nw[k]);
      apb(1'b0, OFS_FLAGS, 32'h0, r, e);
      chk("flags kept", r, 32'ha);
    end
  endtask

  task automatic test_done();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    foreach (prog[i]) prog[i] = 16'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cond();
    t_bra();
    t_bitset();
    test_done();
  end

  // Whole run needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done();
  end
endmodule // branch_and_bit_set_decode_tb_top
